// file: rtl/qpte_pkg.sv
// qpte_pkg.sv: shared constants and message types for the qos enforcer
// Summary of operation
// RULE1: reserved rate is 32-bit bits per second
// RULE2: missing reserved rate means zero reservation
// RULE3: count bytes after header check to CRC
// RULE4: unused reserved rate reported as spare
// RULE5: short packets counted as minimum size
// RULE6: idle expiry nulls both sets, sends change
// RULE7: missing active timeout means never expires
// RULE8: idle timer reloads on acknowledged message
// RULE9: active within admitted within provisioned, clamp
// RULE10: hold expiry trims admitted, sends change
// RULE11: admitted timeout defaults 200 s, zero infinite
// RULE12: hold timer runs while admitted exceeds active
// RULE13: vendor block without leading vendor id dropped
// RULE14: modem caps concatenated burst to limit
// RULE15: zero limit unlimited, default 1522 bytes
// RULE16: burst size excludes physical layer overhead
// RULE17: only head end enforces reserved rate
// RULE18: timers count one-second ticks, flag expiry
// RULE19: reset stops timers and clears expiries
package qpte_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned TICK_PERIOD_NS = 1_000_000_000;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [15:0] ACT_TO_DEFAULT  = 16'h0000;
  localparam logic [15:0] ADM_TO_DEFAULT  = 16'h00C8;
  localparam logic [31:0] RATE_DEFAULT    = 32'h00000000;
  localparam logic [15:0] MIN_PKT_DEFAULT = 16'h0040;
  localparam logic [15:0] BURST_DEFAULT   = 16'h05F2;
  localparam logic [15:0] CONCAT_HDR_LEN  = 16'h0006;
  localparam logic [15:0] MAC_HDR_LEN     = 16'h0006;
  localparam logic [7:0]  VENDOR_ID_TYPE  = 8'h08;
  localparam logic [15:0] PROV_TO_RESET   = 16'hFFFF;
  // register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PROV   = 8'h04;
  localparam logic [7:0] OFS_STATE  = 8'h08;
  localparam logic [7:0] OFS_IRQST  = 8'h0C;
  localparam logic [7:0] OFS_IRQMSK = 8'h10;
  localparam logic [7:0] OFS_RATE   = 8'h14;
  localparam logic [7:0] OFS_BYTES  = 8'h18;
  localparam logic [7:0] OFS_SPARE  = 8'h1C;
  localparam logic [7:0] OFS_TIMERS = 8'h20;
  localparam int unsigned CTRL_REJECT_BIT = 0;
  // interrupt status bit positions
  localparam int unsigned IRQ_IDLE   = 0;
  localparam int unsigned IRQ_HOLD   = 1;
  localparam int unsigned IRQ_VENDOR = 2;
  localparam int unsigned IRQ_REJECT = 3;
  localparam int unsigned IRQ_W      = 4;
  typedef struct packed {
    logic        activates;
    logic        activeNull;
    logic        admitExcess;
    logic        actToPresent;
    logic [15:0] actTo;
    logic        admToPresent;
    logic [15:0] admTo;
    logic        ratePresent;
    logic [31:0] rate;
    logic        minPktPresent;
    logic [15:0] minPkt;
    logic        vendorPresent;
    logic [7:0]  vendorFirst;
  } qpte_msg_t;
  typedef enum logic {QPTE_CHG_NULL, QPTE_CHG_TRIM} qpte_chg_t;
endpackage

// file: rtl/qpte_link_if.sv
// qpte_link_if.sv: message and upstream link between head end and modem
`timescale 1ns/100ps
interface qpte_link_if;
  import qpte_pkg::*;
  logic        msgValid;
  qpte_msg_t   msg;
  logic        rspValid;
  logic        rspAccept;
  logic [15:0] rspActTo;
  logic [15:0] rspAdmTo;
  logic        rspAck;
  logic        chgValid;
  qpte_chg_t   chgCode;
  logic        chgAck;
  logic        upValid;
  logic        upBurstStart;
  logic [15:0] upLen;
  modport head (
    input  msgValid, msg, rspAck, chgAck, upValid, upBurstStart, upLen,
    output rspValid, rspAccept, rspActTo, rspAdmTo, chgValid, chgCode
  );
  modport modem (
    output msgValid, msg, rspAck, chgAck, upValid, upBurstStart, upLen,
    input  rspValid, rspAccept, rspActTo, rspAdmTo, chgValid, chgCode
  );
endinterface

// file: rtl/qpte_timer.sv
// qpte_timer.sv: one-second down-counter with reload and expiry pulse
`timescale 1ns/100ps
module qpte_timer #(
  parameter int unsigned W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         tick,
  input  wire logic         load,
  input  wire logic [W-1:0] loadValue,
  input  wire logic         start,
  input  wire logic         stop,
  input  wire logic         kick,
  output logic      [W-1:0] count,
  output logic              running,
  output logic              expired
);
  logic [W-1:0] reload_reg;
  logic         lastSec;

  assign lastSec = (count == W'(1));

  // reload value kept so activity can restart the interval
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reload_reg <= '0;
    end else if (load) begin
      reload_reg <= loadValue;
    end
  end

  // stop beats load so a nulling message cannot leave it armed
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count   <= '0; // RULE19
      running <= 1'b0; // RULE19
    end else if (stop) begin
      running <= 1'b0;
    end else if (load) begin
      count   <= loadValue;
      running <= start && (loadValue != '0); // RULE7 RULE11
    end else if (kick && running) begin
      count <= reload_reg;
    end else if (tick && running) begin
      count <= count - W'(1); // RULE18
      if (lastSec) begin
        running <= 1'b0;
      end
    end
  end

  // expiry pulse in the same cycle that the count reaches zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      expired <= 1'b0; // RULE19
    end else begin
      expired <= tick && running && lastSec && !stop && !load && !kick;
    end
  end
endmodule

// file: rtl/qpte_head_end.sv
// qpte_head_end.sv: head end timeout, admission and rate accounting
`timescale 1ns/100ps
module qpte_head_end import qpte_pkg::*; #(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  qpte_link_if.head        link
);
  typedef enum {H_IDLE, H_WAIT_ACK, H_CHG} qpte_hstate_t;
  qpte_hstate_t state_reg;

  logic              ctrlReject_reg;
  logic [15:0]       provTo_reg;
  logic [IRQ_W-1:0]  irqStat_reg;
  logic [IRQ_W-1:0]  irqMask_reg;
  logic [IRQ_W-1:0]  irqEvent;
  logic [IRQ_W-1:0]  irqClear;
  logic [31:0]       tickCnt_reg;
  logic              tick;
  logic              activeOn_reg;
  logic              admitExcess_reg;
  logic              pendNull_reg;
  logic              pendTrim_reg;
  logic              msgActivates_reg;
  logic              msgNull_reg;
  logic              msgExcess_reg;
  logic [15:0]       actGrant_reg;
  logic [15:0]       admGrant_reg;
  logic [31:0]       rateNext_reg;
  logic [15:0]       minPktNext_reg;
  logic [31:0]       rate_reg;
  logic [15:0]       minPkt_reg;
  logic [31:0]       bytes_reg;
  logic [31:0]       secBytes_reg;
  logic [31:0]       usedRate_reg;
  logic [31:0]       spare_reg;
  logic [15:0]       actReq;
  logic [15:0]       admReq;
  logic [15:0]       admGrant;
  logic [15:0]       actGrant;
  logic              oversize;
  logic              reject;
  logic              vendorBad;
  logic              msgTake;
  logic              ackTake;
  logic [15:0]       payLen;
  logic [15:0]       billLen;
  logic [15:0]       idleCount;
  logic [15:0]       holdCount;
  logic              idleRun;
  logic              holdRun;
  logic              idleExp;
  logic              holdExp;
  logic              apbWr;
  logic              apbSetup;
  logic              mapped;

  // one-second tick shared by both timers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tickCnt_reg <= '0;
    end else if (tick) begin
      tickCnt_reg <= '0;
    end else begin
      tickCnt_reg <= tickCnt_reg + 32'h00000001;
    end
  end
  assign tick = (tickCnt_reg == 32'(TICK_CYCLES_P - 1)); // RULE18

  // defaults for absent fields, then the ordering clamp
  always_comb begin
    actReq = link.msg.actToPresent ? link.msg.actTo : ACT_TO_DEFAULT; // RULE7
    admReq = link.msg.admToPresent ? link.msg.admTo : ADM_TO_DEFAULT; // RULE11
    admGrant = (admReq > provTo_reg) ? provTo_reg : admReq; // RULE9
    actGrant = (actReq > admGrant) ? admGrant : actReq; // RULE9
    oversize = (admReq > provTo_reg) || (actReq > admGrant);
    reject   = oversize && ctrlReject_reg; // RULE9
    vendorBad = link.msg.vendorPresent &&
                (link.msg.vendorFirst != VENDOR_ID_TYPE); // RULE13
  end

  // a refused request stays up one more cycle while the modem drops it;
  // ignoring it while our answer stands keeps the answer single
  assign msgTake = (state_reg == H_IDLE) && link.msgValid && !link.rspValid;
  assign ackTake = (state_reg == H_WAIT_ACK) && link.rspAck;

  // message sequencing: answer, await acknowledge, or send a change
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg      <= H_IDLE;
      link.rspValid  <= 1'b0;
      link.rspAccept <= 1'b0;
      link.rspActTo  <= '0;
      link.rspAdmTo  <= '0;
      link.chgValid  <= 1'b0;
      link.chgCode   <= QPTE_CHG_NULL;
    end else begin
      link.rspValid <= 1'b0;
      case (state_reg)
        H_IDLE: begin
          if (msgTake) begin
            link.rspValid  <= 1'b1;
            link.rspAccept <= !reject;
            link.rspActTo  <= actGrant; // RULE9
            link.rspAdmTo  <= admGrant;
            if (!reject) begin
              state_reg <= H_WAIT_ACK;
            end
          end else if (!link.msgValid && (pendNull_reg || pendTrim_reg)) begin
            link.chgValid <= 1'b1; // RULE6 RULE10
            link.chgCode  <= pendNull_reg ? QPTE_CHG_NULL : QPTE_CHG_TRIM;
            state_reg     <= H_CHG;
          end
        end
        H_WAIT_ACK: begin
          if (link.rspAck) begin
            state_reg <= H_IDLE;
          end
        end
        H_CHG: begin
          if (link.chgAck) begin
            link.chgValid <= 1'b0;
            state_reg     <= H_IDLE;
          end
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  // parameters held from the answer until the modem acknowledges
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      msgActivates_reg <= 1'b0;
      msgNull_reg      <= 1'b0;
      msgExcess_reg    <= 1'b0;
      actGrant_reg     <= '0;
      admGrant_reg     <= '0;
      rateNext_reg     <= RATE_DEFAULT;
      minPktNext_reg   <= MIN_PKT_DEFAULT;
    end else if (msgTake && !reject) begin
      msgActivates_reg <= link.msg.activates;
      msgNull_reg      <= link.msg.activeNull;
      msgExcess_reg    <= link.msg.admitExcess;
      actGrant_reg     <= actGrant;
      admGrant_reg     <= admGrant;
      rateNext_reg     <= link.msg.ratePresent ? link.msg.rate
                                               : RATE_DEFAULT; // RULE1 RULE2
      minPktNext_reg   <= link.msg.minPktPresent ? link.msg.minPkt
                                                 : MIN_PKT_DEFAULT;
    end
  end

  // parameter sets; timer expiries win over a late acknowledge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      activeOn_reg    <= 1'b0;
      admitExcess_reg <= 1'b0;
      rate_reg        <= RATE_DEFAULT;
      minPkt_reg      <= MIN_PKT_DEFAULT;
    end else if (idleExp) begin
      activeOn_reg    <= 1'b0; // RULE6
      admitExcess_reg <= 1'b0;
    end else if (holdExp) begin
      admitExcess_reg <= 1'b0; // RULE10
    end else if (ackTake) begin
      activeOn_reg    <= !msgNull_reg && (msgActivates_reg || activeOn_reg);
      admitExcess_reg <= msgExcess_reg;
      rate_reg        <= rateNext_reg;
      minPkt_reg      <= minPktNext_reg;
    end
  end

  // pending change requests; a fresh expiry beats the clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pendNull_reg <= 1'b0; // RULE19
      pendTrim_reg <= 1'b0;
    end else begin
      pendNull_reg <= idleExp ||
                      (pendNull_reg && !(state_reg == H_IDLE &&
                       !link.msgValid));
      pendTrim_reg <= holdExp ||
                      (pendTrim_reg && !(state_reg == H_IDLE &&
                       !link.msgValid && !pendNull_reg));
    end
  end

  // idle timer: reloaded on acknowledge, restarted by upstream traffic
  qpte_timer #(.W(16)) idleTimer (
    .clk       (clk),
    .rst_n     (rst_n),
    .tick      (tick),
    .load      (ackTake), // RULE8
    .loadValue (actGrant_reg),
    .start     (msgActivates_reg || activeOn_reg),
    .stop      (ackTake && msgNull_reg), // RULE8
    .kick      (link.upValid),
    .count     (idleCount),
    .running   (idleRun),
    .expired   (idleExp)
  );

  // hold timer: only armed while admitted exceeds active
  qpte_timer #(.W(16)) holdTimer (
    .clk       (clk),
    .rst_n     (rst_n),
    .tick      (tick),
    .load      (ackTake), // RULE12
    .loadValue (admGrant_reg),
    .start     (msgExcess_reg), // RULE12
    .stop      (idleExp), // RULE6
    .kick      (1'b0),
    .count     (holdCount),
    .running   (holdRun),
    .expired   (holdExp)
  );

  // byte accounting from after the header check to the CRC
  always_comb begin
    payLen  = (link.upLen > MAC_HDR_LEN) ? link.upLen - MAC_HDR_LEN
                                         : 16'h0000; // RULE3
    billLen = (payLen < minPkt_reg) ? minPkt_reg : payLen; // RULE5
  end

  // totals and per-second usage; spare is what the flow left unused
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bytes_reg    <= '0;
      secBytes_reg <= '0;
      usedRate_reg <= '0;
      spare_reg    <= '0;
    end else begin
      if (link.upValid) begin
        bytes_reg <= bytes_reg + 32'(billLen); // RULE5
      end
      if (tick) begin
        usedRate_reg <= {secBytes_reg[28:0], 3'b000};
        secBytes_reg <= link.upValid ? 32'(billLen) : 32'h00000000;
      end else if (link.upValid) begin
        secBytes_reg <= secBytes_reg + 32'(billLen);
      end
      spare_reg <= (rate_reg > usedRate_reg) ? rate_reg - usedRate_reg
                                             : 32'h00000000; // RULE4 RULE17
    end
  end

  // register bus: zero wait states, error on unmapped words
  assign apbSetup = psel && !penable;
  assign apbWr    = psel && penable && pwrite;
  assign pready   = 1'b1;
  always_comb begin
    if (paddr == OFS_CTRL || paddr == OFS_PROV || paddr == OFS_STATE) begin
      mapped = 1'b1;
    end else if (paddr == OFS_IRQST || paddr == OFS_IRQMSK) begin
      mapped = 1'b1;
    end else if (paddr == OFS_RATE || paddr == OFS_BYTES) begin
      mapped = 1'b1;
    end else if (paddr == OFS_SPARE || paddr == OFS_TIMERS) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end
  assign pslverr = psel && penable && !mapped;

  // software-written control
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrlReject_reg <= 1'b0;
      provTo_reg     <= PROV_TO_RESET;
      irqMask_reg    <= '0;
    end else if (apbWr) begin
      if (paddr == OFS_CTRL) begin
        ctrlReject_reg <= pwdata[CTRL_REJECT_BIT];
      end else if (paddr == OFS_PROV) begin
        provTo_reg <= pwdata[15:0];
      end else if (paddr == OFS_IRQMSK) begin
        irqMask_reg <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // sticky events, cleared by writing one; a new event wins
  always_comb begin
    irqEvent = '0;
    irqEvent[IRQ_IDLE]   = idleExp;
    irqEvent[IRQ_HOLD]   = holdExp;
    irqEvent[IRQ_VENDOR] = msgTake && vendorBad; // RULE13
    irqEvent[IRQ_REJECT] = msgTake && reject;
    irqClear = (apbWr && paddr == OFS_IRQST) ? pwdata[IRQ_W-1:0] : '0;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqStat_reg <= '0;
    end else begin
      irqStat_reg <= (irqStat_reg & ~irqClear) | irqEvent;
    end
  end
  assign irq = |(irqStat_reg & irqMask_reg);

  // read data captured in the setup cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (apbSetup) begin
      if (paddr == OFS_CTRL) begin
        prdata <= 32'(ctrlReject_reg);
      end else if (paddr == OFS_PROV) begin
        prdata <= {16'h0000, provTo_reg};
      end else if (paddr == OFS_STATE) begin
        prdata <= {28'h0000000, holdRun, idleRun, admitExcess_reg,
                   activeOn_reg};
      end else if (paddr == OFS_IRQST) begin
        prdata <= 32'(irqStat_reg);
      end else if (paddr == OFS_IRQMSK) begin
        prdata <= 32'(irqMask_reg);
      end else if (paddr == OFS_RATE) begin
        prdata <= rate_reg;
      end else if (paddr == OFS_BYTES) begin
        prdata <= bytes_reg;
      end else if (paddr == OFS_SPARE) begin
        prdata <= spare_reg;
      end else if (paddr == OFS_TIMERS) begin
        prdata <= {holdCount, idleCount};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end
endmodule

// file: rtl/qpte_modem_end.sv
// qpte_modem_end.sv: modem side message exchange and burst limiting
`timescale 1ns/100ps
module qpte_modem_end import qpte_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        reqValid,
  input  qpte_msg_t        reqMsg,
  output logic             reqReady,
  output logic             rspDone,
  output logic             rspAccepted,
  output logic      [15:0] grantActTo,
  output logic      [15:0] grantAdmTo,
  output logic             chgEvent,
  output qpte_chg_t        chgKind,
  input  wire logic        burstLimitPresent,
  input  wire logic [15:0] burstLimit,
  input  wire logic        pktValid,
  input  wire logic [15:0] pktLen,
  qpte_link_if.modem       link
);
  typedef enum {M_IDLE, M_WAIT} qpte_mstate_t;
  qpte_mstate_t state_reg;
  logic [15:0]  burst_reg;
  logic [15:0]  limit;
  logic         newBurst;

  assign reqReady = (state_reg == M_IDLE);

  // one request outstanding; malformed vendor block stripped first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg     <= M_IDLE;
      link.msgValid <= 1'b0;
      link.msg      <= '0;
      link.rspAck   <= 1'b0;
      rspDone       <= 1'b0;
      rspAccepted   <= 1'b0;
      grantActTo    <= '0;
      grantAdmTo    <= '0;
    end else begin
      link.rspAck <= 1'b0;
      rspDone     <= 1'b0;
      case (state_reg)
        M_IDLE: begin
          if (reqValid) begin
            link.msgValid <= 1'b1;
            link.msg      <= reqMsg;
            link.msg.vendorPresent <= reqMsg.vendorPresent &&
              (reqMsg.vendorFirst == VENDOR_ID_TYPE); // RULE13
            state_reg <= M_WAIT;
          end
        end
        M_WAIT: begin
          if (link.rspValid) begin
            link.msgValid <= 1'b0;
            link.rspAck   <= link.rspAccept;
            rspDone       <= 1'b1;
            rspAccepted   <= link.rspAccept;
            grantActTo    <= link.rspActTo;
            grantAdmTo    <= link.rspAdmTo;
            state_reg     <= M_IDLE;
          end
        end
        default: state_reg <= M_IDLE;
      endcase
    end
  end

  // change requests acknowledged one cycle after they appear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link.chgAck <= 1'b0;
      chgEvent    <= 1'b0;
      chgKind     <= QPTE_CHG_NULL;
    end else begin
      link.chgAck <= link.chgValid && !link.chgAck;
      chgEvent    <= link.chgValid && !link.chgAck;
      if (link.chgValid && !link.chgAck) begin
        chgKind <= link.chgCode;
      end
    end
  end

  // burst length counts concatenation header plus frames, no phy bytes;
  // the reserved rate is never policed here, the head end owns it
  assign limit = burstLimitPresent ? burstLimit : BURST_DEFAULT; // RULE15
  assign newBurst = (burst_reg == 16'h0000) ||
                    ((limit != 16'h0000) &&
                     (17'(burst_reg) + 17'(pktLen) > 17'(limit))); // RULE14

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      burst_reg         <= '0;
      link.upValid      <= 1'b0;
      link.upBurstStart <= 1'b0;
      link.upLen        <= '0;
    end else begin
      link.upValid      <= pktValid;
      link.upBurstStart <= pktValid && newBurst;
      if (pktValid) begin
        link.upLen <= pktLen;
        burst_reg  <= newBurst ? CONCAT_HDR_LEN + pktLen
                               : burst_reg + pktLen; // RULE16
      end
    end
  end
endmodule

// file: verification/qpte_link_asserts.sv
// qpte_link_asserts.sv: link handshake checks between the two ends
`timescale 1ns/100ps
module qpte_link_asserts import qpte_pkg::*; (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        msgValid,
  input qpte_msg_t        msg,
  input wire logic        rspValid,
  input wire logic        rspAccept,
  input wire logic [15:0] rspActTo,
  input wire logic [15:0] rspAdmTo,
  input wire logic        rspAck,
  input wire logic        chgValid,
  input wire logic        chgAck
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // an accepted answer, then the acknowledge that loads the timers
  sequence s_accept;
    rspValid && rspAccept ##1 rspAck;
  endsequence
  // a busy head end delays the answer by one change handshake only
  property p_rsp_soon; $rose(msgValid) |-> ##[1:8] rspValid; endproperty
  property p_ack; rspValid && rspAccept |-> s_accept; endproperty
  property p_no_ack; rspValid && !rspAccept |=> !rspAck; endproperty
  property p_order; s_accept |-> rspActTo <= rspAdmTo; endproperty
  property p_msg_hold;
    msgValid && !rspValid |=> msgValid && $stable(msg);
  endproperty
  property p_chg_hold; chgValid && !chgAck |=> chgValid; endproperty
  property p_chg_ack; $rose(chgValid) |-> ##[1:2] chgAck; endproperty
  property p_chg_drop; chgAck |=> !chgValid; endproperty
  a_rsp_soon: assert property (p_rsp_soon) else $error("late answer");
  a_ack: assert property (p_ack) else $error("no acknowledge");
  a_no_ack: assert property (p_no_ack) else $error("refused acked");
  a_order: assert property (p_order) else $error("act over adm");
  a_msg_hold: assert property (p_msg_hold) else $error("msg moved");
  a_chg_hold: assert property (p_chg_hold) else $error("change lost");
  a_chg_ack: assert property (p_chg_ack) else $error("chg unacked");
  a_chg_drop: assert property (p_chg_drop) else $error("chg stuck");
endmodule

// file: verification/qos_param_timeout_enforcer_tb_top.sv
// qos_param_timeout_enforcer_tb_top.sv: bench joining both ends
`timescale 1ns/100ps
module qos_param_timeout_enforcer_tb_top import qpte_pkg::*;;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, q;
  logic        pready, pslverr, irq, e, reqValid = 0, reqReady, rspDone;
  logic        rspAccepted, chgEvent, pktValid = 0;
  logic [15:0] grantActTo, grantAdmTo, pktLen = 16'h0000;
  qpte_msg_t   reqMsg = '0;
  qpte_chg_t   chgKind;
  int          n_mismatch = 0, total_checks = 0;
  always #20 clk = ~clk;
  qpte_link_if link ();
  // ten cycles stand for one second to keep the run short
  qpte_head_end #(.TICK_CYCLES_P(10)) i_qpte_head_end (.clk(clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .link(link));
  qpte_modem_end i_qpte_modem_end (.clk(clk), .rst_n(rst_n),
    .reqValid(reqValid), .reqMsg(reqMsg), .reqReady(reqReady),
    .rspDone(rspDone), .rspAccepted(rspAccepted), .grantActTo(grantActTo),
    .grantAdmTo(grantAdmTo), .chgEvent(chgEvent), .chgKind(chgKind),
    .burstLimitPresent(1'b0), .burstLimit(16'h0000), .pktValid(pktValid),
    .pktLen(pktLen), .link(link));
  qpte_link_asserts i_qpte_link_asserts (.clk(clk), .rst_n(rst_n),
    .msgValid(link.msgValid), .msg(link.msg), .rspValid(link.rspValid),
    .rspAccept(link.rspAccept), .rspActTo(link.rspActTo),
    .rspAdmTo(link.rspAdmTo), .rspAck(link.rspAck),
    .chgValid(link.chgValid), .chgAck(link.chgAck));
  task automatic check(input string what, input logic [31:0] s, x);
    total_checks++;
    if (s !== x) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, x, s);
    end
  endtask
  // one apb transfer; waits on pready, never on a fixed count
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // bounded wait for the done pulse so a lost answer cannot hang the run
  task automatic send(input qpte_msg_t m);
    @(posedge clk);
    reqValid <= 1;
    reqMsg <= m;
    do @(posedge clk); while (reqReady !== 1'b1);
    reqValid <= 0;
    for (int i = 0; i < 40 && rspDone !== 1'b1; i++) @(posedge clk);
  endtask
  task automatic pkt(input logic [15:0] n);
    @(posedge clk);
    pktValid <= 1;
    pktLen <= n;
    @(posedge clk);
    pktValid <= 0;
  endtask
  task automatic wait_chg;
    for (int i = 0; i < 300 && chgEvent !== 1'b1; i++) @(posedge clk);
  endtask
  task automatic t_regs;
    apb(0, OFS_PROV, 32'h0);
    check("prov", q, 32'h0000FFFF);
    apb(0, OFS_RATE, 32'h0);
    check("rate", q, 32'h0);
    apb(1, 8'h40, 32'hFFFFFFFF);
    check("unmapped err", e, 32'h1);
  endtask
  // a short frame is billed at the minimum size, payload after header
  task automatic t_bytes;
    pkt(16'h000A);
    @(posedge clk);
    check("burst start", link.upBurstStart, 32'h1);
    pkt(16'h006A);
    @(posedge clk);
    check("same burst", link.upBurstStart, 32'h0);
    pkt(16'h05DC);
    @(posedge clk);
    check("burst split", link.upBurstStart, 32'h1);
    repeat (3) @(posedge clk);
    apb(0, OFS_BYTES, 32'h0);
    check("bytes", q, 32'h0000067A);
  endtask
  task automatic t_clamp;
    send('{ratePresent:1, rate:32'h100, vendorPresent:1, vendorFirst:8'h01,
      default:0});
    check("act default", grantActTo, 32'h0);
    check("adm default", grantAdmTo, 32'h00C8);
    apb(0, OFS_RATE, 32'h0);
    check("rate set", q, 32'h00000100);
    apb(1, OFS_PROV, 32'h5);
    send('{actToPresent:1, actTo:16'h7, admToPresent:1, admTo:16'h9,
      default:0});
    check("adm clamp", grantAdmTo, 32'h5);
    check("act clamp", grantActTo, 32'h5);
    apb(0, OFS_RATE, 32'h0);
    check("rate absent", q, 32'h0);
  endtask
  // idle expiry, then the interrupt is masked and cleared
  task automatic t_idle;
    apb(1, OFS_IRQMSK, 32'h1);
    send('{activates:1, actToPresent:1, actTo:16'h2, admToPresent:1,
      admTo:16'h2, default:0});
    wait_chg;
    check("idle chg", {chgEvent, chgKind}, {1'b1, QPTE_CHG_NULL});
    apb(0, OFS_IRQST, 32'h0);
    check("idle stat", q, 32'h1);
    check("irq on", irq, 32'h1);
    apb(1, OFS_IRQMSK, 32'h0);
    @(posedge clk);
    check("irq masked", irq, 32'h0);
    apb(1, OFS_IRQST, 32'h1);
    apb(0, OFS_IRQST, 32'h0);
    check("cleared", q, 32'h0);
  endtask
  task automatic t_hold;
    send('{activeNull:1, admitExcess:1, admToPresent:1, admTo:16'h1,
      default:0});
    wait_chg;
    check("hold chg", {chgEvent, chgKind}, {1'b1, QPTE_CHG_TRIM});
  endtask
  task automatic t_reject;
    apb(1, OFS_CTRL, 32'h1);
    send('{activeNull:1, admToPresent:1, admTo:16'h9, default:0});
    check("refused", rspAccepted, 32'h0);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // the whole sequence needs well under two thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    end_of_test;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    t_regs;
    t_bytes;
    t_clamp;
    t_idle;
    t_hold;
    t_reject;
    end_of_test;
  end
endmodule
